// *** include/ceg_params.svh ***
// Contract
// RULE1 - Machine ISA, machine env and supervisor env enable bits are writable.
// RULE2 - Effective enable: M uses ISA bit; S adds machine env; U adds supervisor env.
// RULE3 - Reset clears the ISA enable; pc and ddc bounds start as root capabilities.
// RULE4 - With enable zero, pc and ddc bounds are still enforced.
// RULE5 - With enable zero, every capability and hybrid instruction is illegal. The code instead decodes compressed capability encodings as standard.
// RULE6 - With enable zero, CSR instructions on native capability CSRs are illegal.
// RULE7 - With enable zero, widened CSRs are accessed at integer width only.
// RULE8 - Disabling leaves implicit accesses using the last written pc and ddc.
// RULE9 - Data accesses use ddc unless enabled with mode bit zero, then rs1. The code also keeps ddc in debug mode.
// RULE10 - With enable one, native capability CSRs are capability width in both modes.
// RULE11 - Widened CSRs are capability width only with enable one and mode bit zero.
// RULE12 - Enable one, mode one: compressed capability encodings decode as standard.
// RULE13 - Effective enable is recomputed continually and applies from the next instruction.
`ifndef CEG_PARAMS_SVH
`define CEG_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define CEG_ADDR_W 4
`define CEG_OFF_CTRL 4'h0
`define CEG_OFF_STATE 4'h4
`define CEG_OFF_IRQ_STAT 4'h8
`define CEG_OFF_IRQ_MASK 4'hC

// ****************************************
// Field positions and reset values
// ****************************************
`define CEG_BIT_ISA 0
`define CEG_BIT_MENV 1
`define CEG_BIT_SENV 2
`define CEG_EN_RST 3'h0
`define CEG_EV_W 3
`define CEG_EV_CAP 0
`define CEG_EV_CSR 1
`define CEG_EV_CHG 2
`define CEG_MASK_RST 3'h0
`define CEG_RESP_OKAY 2'h0
`define CEG_RESP_SLVERR 2'h2

`endif

// *** include/ceg_pkg.sv ***
package ceg_pkg;

	typedef enum logic [1:0]
	{
		CEG_PRIV_U = 2'h0,
		CEG_PRIV_S = 2'h1,
		CEG_PRIV_M = 2'h3
	} ceg_priv_t;

	typedef enum logic [1:0]
	{
		CEG_AXW_IDLE = 2'h0,
		CEG_AXW_HAVE = 2'h1,
		CEG_AXW_RESP = 2'h2
	} ceg_axw_t;

endpackage : ceg_pkg

// *** design/ceg_enable_calc.sv ***
`timescale 1ns/1ns
`include "ceg_params.svh"

module ceg_enable_calc
(
	// Privilege and enable bits
	input wire logic [1:0] priv_i,
	input wire logic [2:0] en_bits_i,
	// Effective enable
	output logic eff_o
);

	always_comb
	begin
		unique case (priv_i)
			ceg_pkg::CEG_PRIV_M: eff_o = en_bits_i[`CEG_BIT_ISA]; // [RULE2]
			ceg_pkg::CEG_PRIV_S: eff_o = en_bits_i[`CEG_BIT_ISA] & en_bits_i[`CEG_BIT_MENV];
			ceg_pkg::CEG_PRIV_U: eff_o = &en_bits_i;
			// Reserved privilege code: treat as disabled
			default: eff_o = 1'b0;
		endcase
	end

endmodule : ceg_enable_calc

// *** design/ceg_csr_width.sv ***
`timescale 1ns/1ns

module ceg_csr_width
(
	// Access class
	input wire logic eff_i,
	input wire logic mode_i,
	input wire logic native_i,
	input wire logic widened_i,
	// Decision
	output logic illegal_o,
	output logic cap_width_o
);

	assign illegal_o = native_i & ~eff_i; // [RULE6]
	// Widened CSRs fall back to integer width as in address mode
	assign cap_width_o = (native_i & eff_i) // [RULE10]
		| (widened_i & eff_i & ~mode_i); // [RULE7] [RULE11]

endmodule : ceg_csr_width

// *** design/ceg_gate.sv ***
`timescale 1ns/1ns
`include "ceg_params.svh"

module ceg_gate
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Hart state
	input wire logic [1:0] priv_i,
	input wire logic mode_bit_i,
	input wire logic debug_mode_i,
	// Hart CSR writes of the enable bits
	input wire logic [2:0] en_we_i,
	input wire logic [2:0] en_wdata_i,
	output logic [2:0] en_bits_o,
	// Decode request
	input wire logic req_valid_i,
	input wire logic instr_cap_i,
	input wire logic instr_cap_cmp_i,
	input wire logic csr_req_i,
	input wire logic csr_native_i,
	input wire logic csr_widened_i,
	input wire logic mem_req_i,
	// Decode answer
	output logic resp_valid_o,
	output logic illegal_o,
	output logic use_std_cmp_o,
	output logic csr_cap_width_o,
	output logic auth_ddc_o,
	output logic eff_en_o,
	// Capability state control
	output logic root_load_o,
	output logic bounds_check_o,
	// AXI4-Lite write
	input wire logic [`CEG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`CEG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq_o
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [2:0] en_bits;
	logic eff_en;
	logic next_eff;
	logic [`CEG_EV_W-1:0] irq_stat;
	logic [`CEG_EV_W-1:0] irq_mask;
	logic [`CEG_EV_W-1:0] ev;
	logic aw_have;
	logic w_have;
	logic [`CEG_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic wr_ctrl;
	logic wr_ok;
	logic [31:0] rd_val;
	logic rd_ok;
	logic csr_ill;
	logic csr_cw;
	logic cap_ill;
	logic std_cmp;
	logic root_done;

	// ****************************************
	// Effective enable
	// ****************************************
	ceg_enable_calc u_calc
	(
		.priv_i(priv_i),
		.en_bits_i(en_bits),
		.eff_o(next_eff)
	);

	// Registered so a change applies from the next instruction
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			eff_en <= 1'b0;
		else
			eff_en <= next_eff; // [RULE13]
	end

	// ****************************************
	// Enable bits
	// ****************************************
	assign wr_do = aw_have & w_have & ~s_axi_bvalid;
	assign wr_ctrl = wr_do & (aw_addr == `CEG_OFF_CTRL) & w_strb[0];

	// Hart CSR write wins over a bus write in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			en_bits <= `CEG_EN_RST; // [RULE3]
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (en_we_i[i])
					en_bits[i] <= en_wdata_i[i]; // [RULE1]
				else if (wr_ctrl)
					en_bits[i] <= w_data[i]; // [RULE1]
			end
		end
	end

	// ****************************************
	// Decode answer
	// ****************************************
	ceg_csr_width u_csr
	(
		.eff_i(eff_en),
		.mode_i(mode_bit_i),
		.native_i(csr_req_i & csr_native_i),
		.widened_i(csr_req_i & csr_widened_i),
		.illegal_o(csr_ill),
		.cap_width_o(csr_cw)
	);

	// Compressed capability-data encodings revert to standard meaning
	assign std_cmp = instr_cap_cmp_i & (~eff_en | mode_bit_i); // [RULE12]
	assign cap_ill = instr_cap_i & ~eff_en & ~std_cmp; // [RULE5]

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			resp_valid_o <= 1'b0;
			illegal_o <= 1'b0;
			use_std_cmp_o <= 1'b0;
			csr_cap_width_o <= 1'b0;
			auth_ddc_o <= 1'b1;
		end
		else
		begin
			resp_valid_o <= req_valid_i;
			illegal_o <= req_valid_i & (cap_ill | csr_ill); // [RULE5] [RULE6]
			use_std_cmp_o <= req_valid_i & std_cmp; // [RULE12]
			csr_cap_width_o <= req_valid_i & csr_cw; // [RULE7] [RULE10] [RULE11]
			// Debug mode keeps ddc as the authority
			auth_ddc_o <= ~eff_en | mode_bit_i | debug_mode_i; // [RULE9]
		end
	end

	// ****************************************
	// Capability state control
	// ****************************************
	// The enable never gates pc/ddc checks, so the last written caps keep ruling
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			root_done <= 1'b0;
			root_load_o <= 1'b1; // [RULE3]
			bounds_check_o <= 1'b1;
		end
		else
		begin
			root_done <= 1'b1;
			root_load_o <= ~root_done;
			bounds_check_o <= 1'b1; // [RULE4] [RULE8]
		end
	end

	assign en_bits_o = en_bits;
	assign eff_en_o = eff_en;

	// ****************************************
	// Interrupts
	// ****************************************
	assign ev[`CEG_EV_CAP] = req_valid_i & cap_ill;
	assign ev[`CEG_EV_CSR] = req_valid_i & csr_ill;
	assign ev[`CEG_EV_CHG] = next_eff ^ eff_en;

	// Set wins over a write-one clear
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			irq_stat <= '0;
		else if (wr_do & (aw_addr == `CEG_OFF_IRQ_STAT) & w_strb[0])
			irq_stat <= (irq_stat & ~w_data[`CEG_EV_W-1:0]) | ev;
		else
			irq_stat <= irq_stat | ev;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			irq_mask <= `CEG_MASK_RST;
		else if (wr_do & (aw_addr == `CEG_OFF_IRQ_MASK) & w_strb[0])
			irq_mask <= w_data[`CEG_EV_W-1:0];
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign s_axi_awready = ~aw_have;
	assign s_axi_wready = ~w_have;
	assign wr_ok = (aw_addr == `CEG_OFF_CTRL) | (aw_addr == `CEG_OFF_IRQ_STAT)
		| (aw_addr == `CEG_OFF_IRQ_MASK);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			aw_have <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid & ~aw_have)
		begin
			aw_have <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (wr_do)
			aw_have <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			w_have <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid & ~w_have)
		begin
			w_have <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (wr_do)
			w_have <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CEG_RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `CEG_RESP_OKAY : `CEG_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb
	begin
		rd_val = '0;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			`CEG_OFF_CTRL: rd_val[2:0] = en_bits;
			`CEG_OFF_STATE: rd_val[4:0] = {priv_i, debug_mode_i, mode_bit_i, eff_en};
			`CEG_OFF_IRQ_STAT: rd_val[`CEG_EV_W-1:0] = irq_stat;
			`CEG_OFF_IRQ_MASK: rd_val[`CEG_EV_W-1:0] = irq_mask;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `CEG_RESP_OKAY;
		end
		else if (s_axi_arvalid & ~s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? `CEG_RESP_OKAY : `CEG_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	AST_RST_OFF: assert property ($fell(reset_i) |-> !en_bits[`CEG_BIT_ISA] && root_load_o) // [RULE3]
		else $error("ISA enable not clear after reset");
	AST_CTRL_WR: assert property (wr_ctrl && en_we_i == 3'h0 |=> en_bits == $past(w_data[2:0])) // [RULE1]
		else $error("Enable bits did not take bus write");
	AST_EFF_M: assert property (priv_i == ceg_pkg::CEG_PRIV_M |=> eff_en == $past(en_bits[0])) // [RULE2]
		else $error("Machine effective enable wrong");
	AST_EFF_U: assert property (priv_i == ceg_pkg::CEG_PRIV_U |=> eff_en == $past(&en_bits)) // [RULE2]
		else $error("User effective enable wrong");
	AST_EFF_LAG: assert property (next_eff != eff_en |=> eff_en == $past(next_eff)) // [RULE13]
		else $error("Effective enable did not follow");
	AST_CAP_ILL: assert property (req_valid_i && instr_cap_i && !instr_cap_cmp_i && !eff_en
		|=> resp_valid_o && illegal_o) // [RULE5]
		else $error("Capability instruction not trapped");
	AST_CSR_NAT_OFF: assert property (req_valid_i && csr_req_i && csr_native_i && !eff_en
		|=> illegal_o) // [RULE6]
		else $error("Native capability CSR not trapped");
	AST_CSR_WID_OFF: assert property (req_valid_i && csr_req_i && csr_widened_i && !eff_en
		|=> !csr_cap_width_o) // [RULE7]
		else $error("Widened CSR wide while disabled");
	AST_CSR_NAT_ON: assert property (req_valid_i && csr_req_i && csr_native_i && eff_en
		|=> csr_cap_width_o && !illegal_o) // [RULE10]
		else $error("Native CSR not full width");
	AST_CSR_WID_ON: assert property (req_valid_i && csr_req_i && csr_widened_i && !csr_native_i
		|=> csr_cap_width_o == $past(eff_en && !mode_bit_i)) // [RULE11]
		else $error("Widened CSR width wrong");
	AST_AUTH: assert property (!debug_mode_i |=> auth_ddc_o == $past(!eff_en || mode_bit_i)) // [RULE9]
		else $error("Wrong authorizing capability");
	AST_CMP_STD: assert property (req_valid_i && instr_cap_i && instr_cap_cmp_i && eff_en
		&& mode_bit_i |=> use_std_cmp_o && !illegal_o) // [RULE12]
		else $error("Compressed encoding not standard");
	AST_BOUNDS: assert property (!eff_en |-> ##1 bounds_check_o) // [RULE4] [RULE8]
		else $error("Bounds checks dropped while disabled");

endmodule : ceg_gate

// *** verification/ceg_hart_model.sv ***
`timescale 1ns/1ns

module ceg_hart_model
(
	// Request kind
	input wire logic [2:0] kind_i,
	// Decode flags
	output logic instr_cap_o,
	output logic instr_cap_cmp_o,
	output logic csr_req_o,
	output logic csr_native_o,
	output logic csr_widened_o,
	output logic mem_req_o
);
	// Kinds: 1 cap, 2 compressed cap, 3 native csr, 4 widened csr, 5 load
	assign instr_cap_o = (kind_i == 3'h1) || (kind_i == 3'h2);
	assign instr_cap_cmp_o = kind_i == 3'h2;
	assign csr_req_o = (kind_i == 3'h3) || (kind_i == 3'h4);
	assign csr_native_o = kind_i == 3'h3;
	assign csr_widened_o = kind_i == 3'h4;
	assign mem_req_o = kind_i == 3'h5;
endmodule : ceg_hart_model

// *** verification/ceg_gate_bench.sv ***
`timescale 1ns/1ns
`include "ceg_params.svh"

module ceg_gate_bench;
	logic clk_i, reset_i, mode, dbg, req, awv, wv, bready, arv, rready;
	logic [1:0] priv, bresp, rresp;
	logic [2:0] en_we, en_wd, kind, en_bits;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic ic, icc, cr, cn, cw, mr, rv, ill, ustd, cwid, auth, eff, rootl, bchk, irq;
	logic awr, wr, bv, arr, rvl;
	int err_count, n_tests;
	logic [1:0] resp;

	ceg_hart_model ceg_hart_model_inst (.kind_i(kind), .instr_cap_o(ic),
		.instr_cap_cmp_o(icc), .csr_req_o(cr), .csr_native_o(cn),
		.csr_widened_o(cw), .mem_req_o(mr));
	ceg_gate ceg_gate_inst (.clk_i(clk_i), .reset_i(reset_i), .priv_i(priv),
		.mode_bit_i(mode), .debug_mode_i(dbg), .en_we_i(en_we), .en_wdata_i(en_wd),
		.en_bits_o(en_bits), .req_valid_i(req), .instr_cap_i(ic), .instr_cap_cmp_i(icc),
		.csr_req_i(cr), .csr_native_i(cn), .csr_widened_i(cw), .mem_req_i(mr),
		.resp_valid_o(rv), .illegal_o(ill), .use_std_cmp_o(ustd),
		.csr_cap_width_o(cwid), .auth_ddc_o(auth), .eff_en_o(eff),
		.root_load_o(rootl), .bounds_check_o(bchk), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl),
		.s_axi_rready(rready), .irq_o(irq));

	// ****************************************
	// Checking and closing
	// ****************************************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
			err_count++;
		end
	endtask : chk

	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ****************************************
	// Bus and decode tasks
	// ****************************************
	// Read just after an edge, a handshake output still shows its value at that edge
	task axw(input logic [3:0] a, input logic [31:0] d);
		logic ah, wh;
		ah = 1'b1;
		wh = 1'b1;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		while (ah || wh)
		begin
			@(posedge clk_i);
			if (ah && awr)
			begin
				awv <= 1'b0;
				ah = 1'b0;
			end
			if (wh && wr)
			begin
				wv <= 1'b0;
				wh = 1'b0;
			end
		end
		do @(posedge clk_i); while (bv !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axw

	task axr(input logic [3:0] a);
		@(posedge clk_i);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge clk_i); while (rvl !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axr

	task st(input logic [1:0] p, input logic m, input logic [2:0] en);
		@(posedge clk_i);
		priv <= p;
		mode <= m;
		en_we <= 3'h7;
		en_wd <= en;
		@(posedge clk_i);
		en_we <= 3'h0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask : st

	task dec(input logic [2:0] k);
		@(posedge clk_i);
		req <= 1'b1;
		kind <= k;
		@(posedge clk_i);
		req <= 1'b0;
		kind <= 3'h0;
		#1;
	endtask : dec

	function automatic logic f_eff(input logic [1:0] p, input logic [2:0] en);
		return p == 2'h3 ? en[0] : p == 2'h1 ? &en[1:0] : p == 2'h0 ? &en : 1'b0;
	endfunction : f_eff

	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		end_sim();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{reset_i, priv, mode, dbg, en_we, en_wd, req, kind} = {1'b1, 2'h3, 12'h000};
		{awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
		err_count = 0;
		n_tests = 0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("root_load", rootl, 1);
		chk("en_bits", en_bits, 0);
		chk("eff", eff, 0);
		chk("auth", auth, 1);
		@(posedge clk_i);
		#1;
		chk("root_load off", rootl, 0);
		$display("test reset done");
		for (int p = 0; p < 4; p++)
			for (int en = 0; en < 8; en++)
			begin
				st(p[1:0], 1'b0, en[2:0]);
				chk("en_bits", en_bits, en);
				chk("eff", eff, f_eff(p[1:0], en[2:0]));
			end
		st(2'h3, 1'b0, 3'h0);
		axw(`CEG_OFF_CTRL, 32'h00000007);
		chk("ctrl resp", resp, `CEG_RESP_OKAY);
		axr(`CEG_OFF_CTRL);
		chk("ctrl", rd[2:0], 3'h7);
		repeat (2) @(posedge clk_i);
		#1;
		chk("eff bus", eff, 1);
		axr(`CEG_OFF_STATE);
		chk("state", rd[4:0], 5'h19);
		$display("test enable done");
		for (int en = 0; en < 2; en++)
			for (int m = 0; m < 2; m++)
			begin
				st(2'h3, m[0], {2'h0, en[0]});
				for (int k = 1; k < 6; k++)
				begin
					dec(k[2:0]);
					chk("resp", rv, 1);
					chk("bounds", bchk, 1);
					chk("auth", auth, !en[0] || m[0]);
					chk("std", ustd, k == 2 && (!en[0] || m[0]));
					chk("ill", ill, !en[0] && (k == 1 || k == 3));
					chk("width", cwid, en[0] && (k == 3 || (k == 4 && !m[0])));
				end
			end
		@(posedge clk_i);
		dbg <= 1'b1;
		st(2'h3, 1'b0, 3'h1);
		chk("auth dbg", auth, 1);
		@(posedge clk_i);
		dbg <= 1'b0;
		$display("test decode done");
		st(2'h3, 1'b0, 3'h0);
		axw(`CEG_OFF_IRQ_STAT, 32'h00000007);
		axw(`CEG_OFF_IRQ_MASK, 32'h00000001);
		#1;
		chk("irq idle", irq, 0);
		dec(3'h1);
		@(posedge clk_i);
		#1;
		chk("irq set", irq, 1);
		axr(`CEG_OFF_IRQ_STAT);
		chk("stat", rd[0], 1);
		axw(`CEG_OFF_IRQ_STAT, 32'h00000001);
		repeat (2) @(posedge clk_i);
		#1;
		chk("irq clr", irq, 0);
		axw(`CEG_OFF_STATE, 32'h00000001);
		chk("ro resp", resp, `CEG_RESP_SLVERR);
		axr(4'h2);
		chk("unmapped resp", resp, `CEG_RESP_SLVERR);
		chk("unmapped data", rd, 0);
		$display("test bus done");
		end_sim();
	end
endmodule : ceg_gate_bench
